// [design/qfp_pkg.sv]
// Shared constants and types for the four-channel input filter block
package qfp_pkg;

  localparam int CLK_PERIOD_NS = 25;

  // Filter times in ns and the derived clock counts
  localparam int T_1US_NS    = 1000;
  localparam int T_3US_NS    = 3000;
  localparam int T_10US_NS   = 10000;
  localparam int T_86US_NS   = 86000;
  localparam int T_342US_NS  = 342000;
  localparam int T_2731US_NS = 2731000;
  localparam int CYC_1US     = (T_1US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_3US     = (T_3US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_10US    = (T_10US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_86US    = (T_86US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_342US   = (T_342US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_2731US  = (T_2731US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W  = 17;
  localparam int NUM_CH = 4;

  // Permitted delay codes
  localparam logic [7:0] DLY_1US    = 8'h00;
  localparam logic [7:0] DLY_3US    = 8'h02;
  localparam logic [7:0] DLY_10US   = 8'h04;
  localparam logic [7:0] DLY_86US   = 8'h07;
  localparam logic [7:0] DLY_342US  = 8'h09;
  localparam logic [7:0] DLY_2731US = 8'h0C;

  // Diagnostic enable encodings
  localparam logic [7:0] DIAG_OFF = 8'h00;
  localparam logic [7:0] DIAG_ON  = 8'h40;

  // Reset values
  localparam logic [7:0] RST_DIAG_EN = 8'h00;
  localparam logic [7:0] RST_DELAY   = 8'h02;
  localparam logic [3:0] RST_MASK    = 4'h0;

  // Record-set numbers and byte counts
  localparam logic [15:0] REC_DIAG   = 16'h0000;
  localparam logic [15:0] REC_DELAY  = 16'h0001;
  localparam logic [15:0] REC_MASK   = 16'h0080;
  localparam logic [7:0]  REC_DELAY_LEN = 8'h04;
  localparam logic [7:0]  REC_MASK_LEN  = 8'h02;

  // Object index range and subindex range
  localparam logic [15:0] OBJ_FIRST = 16'h3100;
  localparam logic [15:0] OBJ_LAST  = 16'h3106;
  localparam logic [7:0]  SUB_FIRST = 8'h01;
  localparam logic [7:0]  SUB_LAST  = 8'h07;

  // Parameter slots
  localparam logic [2:0] SLOT_DIAG  = 3'h0;
  localparam logic [2:0] SLOT_DLY0  = 3'h1;
  localparam logic [2:0] SLOT_RISE  = 3'h5;
  localparam logic [2:0] SLOT_FALL  = 3'h6;
  localparam logic [2:0] SLOT_NONE  = 3'h7;

  typedef enum logic [1:0] {
    MODE_RECORD,
    MODE_OBJECT,
    MODE_ECAT,
    MODE_SPARE
  } qfp_mode_t;

endpackage : qfp_pkg

// [design/qfp_filter.sv]
// One input delay filter channel
`timescale 1ns/1ps
`default_nettype none

module qfp_filter (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic                       ce,
  input  wire logic                       raw,
  input  wire logic [qfp_pkg::CNT_W-1:0]  limit,
  output logic                            level
);

  typedef struct packed {
    logic [qfp_pkg::CNT_W-1:0] cnt;
    logic                      level;
  } qfp_flt_st_t;

  qfp_flt_st_t flt_reg;
  qfp_flt_st_t flt_next;
  logic        fire;

  // Same counter for both directions, so rise and fall are delayed alike
  always_comb begin
    flt_next = flt_reg;
    fire     = 1'b0;
    if (raw == flt_reg.level) begin
      flt_next.cnt = '0; // R16
    end else if (flt_reg.cnt >= limit - 17'h1) begin
      fire           = ce;
      flt_next.level = raw; // R03 R04
      flt_next.cnt   = '0;
    end else begin
      flt_next.cnt = flt_reg.cnt + 17'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flt_reg <= '0;
    end else if (ce) begin
      flt_reg <= flt_next;
    end
  end

  assign level = flt_reg.level;

  AST_FLT_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R16
    $changed(flt_reg.level) |-> $past(fire))
    else $error("Filter level changed before the delay elapsed");

  AST_FLT_COUNT: assert property (@(posedge sys_clk) disable iff (rst) // R16
    (ce && raw == flt_reg.level) |=> flt_reg.cnt == 17'h0)
    else $error("Filter counter not cleared when input matches level");

endmodule : qfp_filter

`default_nettype wire

// [design/qfp_top.sv]
// Four-channel filtered input stage with its parameter set
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R01) Four independent input channels, all usable together.
// (R02) Delay code picks filter time 1, 3, 10, 86, 342 or 2731 us.
// (R03) Each channel filtered on its own to suppress spikes.
// (R04) Same delay applies to rising and falling transitions.
// (R05) Diagnostics on at 40h, off at 00h; resets to 00h.
// (R06) Host writes diagnostic enable only while system is stopped; the block accepts the write at any time.
// (R07) Rising-edge interrupt mask, reset 00h.
// (R08) Falling-edge interrupt mask, reset 00h.
// (R09) Records: 00h diagnostic, 01h four delays, 80h both masks.
// (R10) Object indices 3100h to 3106h in parameter order.
// (R11) Ethernet indices 3100h plus slot, subindex 01h to 07h.
// (R12) One status light per channel shows its current state.
// (R13) Input image bit n is channel n; bits 7 to 4 zero.
// (R14) Rising mask bit n enables channel n; upper bits reserved.
// (R15) Falling mask bit n enables channel n; upper bits reserved.
// (R16) New level passes only after raw input held for the delay.
// (R17) Illegal delay code is refused; old code stays.
module qfp_top #(
  parameter logic [qfp_pkg::CNT_W-1:0] CYC_342US  = qfp_pkg::CNT_W'(qfp_pkg::CYC_342US),
  parameter logic [qfp_pkg::CNT_W-1:0] CYC_2731US = qfp_pkg::CNT_W'(qfp_pkg::CYC_2731US)
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  input  wire logic [3:0]         input_channel,
  input  wire logic               par_wr,
  input  wire logic               par_rd,
  input  wire qfp_pkg::qfp_mode_t par_mode,
  input  wire logic [15:0]        par_addr,
  input  wire logic [7:0]         par_sub,
  input  wire logic [7:0]         par_wdata,
  input  wire logic [7:0]         ecat_slot,
  output logic [7:0]              par_rdata,
  output logic                    par_ack,
  output logic                    par_err,
  output logic [7:0]              input_image,
  output logic [3:0]              status_led,
  output logic                    diag_active,
  output logic [3:0]              edge_event,
  output logic [3:0]              edge_snapshot
);

  typedef struct packed {
    logic [3:0]      sync1;
    logic [3:0]      sync2;
    logic [7:0]      diag_en;
    logic [3:0][7:0] dly;
    logic [3:0]      rise_mask;
    logic [3:0]      fall_mask;
    logic [7:0]      image;
    logic [3:0]      led;
    logic            diag_act;
    logic [3:0]      evt;
    logic [3:0]      snap;
    logic [7:0]      rdata;
    logic            ack;
    logic            err;
  } qfp_top_st_t;

  localparam qfp_top_st_t RST_ST = '{
    sync1:     4'h0,
    sync2:     4'h0,
    diag_en:   qfp_pkg::RST_DIAG_EN,
    dly:       {4{qfp_pkg::RST_DELAY}},
    rise_mask: qfp_pkg::RST_MASK,
    fall_mask: qfp_pkg::RST_MASK,
    image:     8'h00,
    led:       4'h0,
    diag_act:  1'b0,
    evt:       4'h0,
    snap:      4'h0,
    rdata:     8'h00,
    ack:       1'b0,
    err:       1'b0
  };

  qfp_top_st_t st_reg;
  qfp_top_st_t st_next;
  logic [3:0]  filt;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [2:0]  slot;
  logic [15:0] ecat_base;
  logic [3:0][qfp_pkg::CNT_W-1:0] limit;

  function automatic logic code_ok(input logic [7:0] code);
    case (code)
      qfp_pkg::DLY_1US, qfp_pkg::DLY_3US, qfp_pkg::DLY_10US,
      qfp_pkg::DLY_86US, qfp_pkg::DLY_342US, qfp_pkg::DLY_2731US: code_ok = 1'b1;
      default: code_ok = 1'b0;
    endcase
  endfunction : code_ok

  // Decode of the three access schemes onto one slot number
  always_comb begin
    ecat_base = qfp_pkg::OBJ_FIRST + {8'h00, ecat_slot};
    slot      = qfp_pkg::SLOT_NONE;
    case (par_mode)
      qfp_pkg::MODE_RECORD: begin
        if (par_addr == qfp_pkg::REC_DIAG && par_sub == 8'h00) begin
          slot = qfp_pkg::SLOT_DIAG; // R09
        end else if (par_addr == qfp_pkg::REC_DELAY && par_sub < qfp_pkg::REC_DELAY_LEN) begin
          slot = qfp_pkg::SLOT_DLY0 + par_sub[2:0]; // R09
        end else if (par_addr == qfp_pkg::REC_MASK && par_sub < qfp_pkg::REC_MASK_LEN) begin
          slot = qfp_pkg::SLOT_RISE + par_sub[2:0]; // R09
        end
      end
      qfp_pkg::MODE_OBJECT: begin
        if (par_addr >= qfp_pkg::OBJ_FIRST && par_addr <= qfp_pkg::OBJ_LAST) begin
          slot = par_addr[2:0]; // R10
        end
      end
      qfp_pkg::MODE_ECAT: begin
        if (par_addr == ecat_base && par_sub >= qfp_pkg::SUB_FIRST
            && par_sub <= qfp_pkg::SUB_LAST) begin
          slot = par_sub[2:0] - 3'h1; // R11
        end
      end
      default: slot = qfp_pkg::SLOT_NONE;
    endcase
  end

  // Delay code to cycle count; unknown codes never get stored
  always_comb begin
    for (int i = 0; i < qfp_pkg::NUM_CH; i++) begin
      case (st_reg.dly[i])
        qfp_pkg::DLY_1US:    limit[i] = qfp_pkg::CNT_W'(qfp_pkg::CYC_1US); // R02
        qfp_pkg::DLY_3US:    limit[i] = qfp_pkg::CNT_W'(qfp_pkg::CYC_3US);
        qfp_pkg::DLY_10US:   limit[i] = qfp_pkg::CNT_W'(qfp_pkg::CYC_10US);
        qfp_pkg::DLY_86US:   limit[i] = qfp_pkg::CNT_W'(qfp_pkg::CYC_86US);
        qfp_pkg::DLY_342US:  limit[i] = CYC_342US;
        qfp_pkg::DLY_2731US: limit[i] = CYC_2731US;
        default:             limit[i] = qfp_pkg::CNT_W'(qfp_pkg::CYC_3US);
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < qfp_pkg::NUM_CH; g++) begin : g_ch
      qfp_filter u_filter ( // R01 R03
        .sys_clk (sys_clk),
        .rst     (rst),
        .ce      (ce),
        .raw     (st_reg.sync2[g]),
        .limit   (limit[g]),
        .level   (filt[g])
      );
    end
  endgenerate

  assign rise = filt & ~st_reg.image[3:0];
  assign fall = ~filt & st_reg.image[3:0];

  always_comb begin
    st_next       = st_reg;
    st_next.ack   = 1'b0;
    st_next.sync1 = input_channel;
    st_next.sync2 = st_reg.sync1;
    st_next.image = {4'h0, filt}; // R13
    st_next.led   = filt; // R12
    st_next.diag_act = (st_reg.diag_en == qfp_pkg::DIAG_ON); // R05
    // Events come from the filtered level, so spikes never raise one
    st_next.evt = (rise & st_reg.rise_mask) | (fall & st_reg.fall_mask); // R07 R08 R14 R15
    if (|st_next.evt) begin
      st_next.snap = filt;
    end
    if (par_wr || par_rd) begin
      st_next.ack = 1'b1;
      st_next.err = 1'b0;
      st_next.rdata = 8'h00;
      case (slot)
        qfp_pkg::SLOT_DIAG: begin
          st_next.rdata = st_reg.diag_en;
          if (par_wr) begin
            if (par_wdata == qfp_pkg::DIAG_ON || par_wdata == qfp_pkg::DIAG_OFF) begin
              st_next.diag_en = par_wdata; // R05 R06
            end else begin
              st_next.err = 1'b1;
            end
          end
        end
        3'h1, 3'h2, 3'h3, 3'h4: begin
          st_next.rdata = st_reg.dly[slot - qfp_pkg::SLOT_DLY0];
          if (par_wr) begin
            if (code_ok(par_wdata)) begin
              st_next.dly[slot - qfp_pkg::SLOT_DLY0] = par_wdata; // R02
            end else begin
              st_next.err = 1'b1; // R17
            end
          end
        end
        qfp_pkg::SLOT_RISE: begin
          st_next.rdata = {4'h0, st_reg.rise_mask}; // R14
          if (par_wr) begin
            st_next.rise_mask = par_wdata[3:0]; // R07
          end
        end
        qfp_pkg::SLOT_FALL: begin
          st_next.rdata = {4'h0, st_reg.fall_mask}; // R15
          if (par_wr) begin
            st_next.fall_mask = par_wdata[3:0]; // R08
          end
        end
        default: st_next.err = 1'b1;
      endcase
    end
  end

  // Clock enable low freezes every flip-flop including the synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg <= RST_ST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign par_rdata     = st_reg.rdata;
  assign par_ack       = st_reg.ack;
  assign par_err       = st_reg.err;
  assign input_image   = st_reg.image;
  assign status_led    = st_reg.led;
  assign diag_active   = st_reg.diag_act;
  assign edge_event    = st_reg.evt;
  assign edge_snapshot = st_reg.snap;

  AST_IMAGE_RSV: assert property (@(posedge sys_clk) disable iff (rst) // R13
    input_image[7:4] == 4'h0 && status_led == input_image[3:0])
    else $error("Image upper bits set or lights disagree with image");

  AST_IMAGE_FOLLOW: assert property (@(posedge sys_clk) disable iff (rst) // R13
    ce |=> input_image[3:0] == $past(filt))
    else $error("Input image does not follow the filtered levels");

  AST_LED: assert property (@(posedge sys_clk) disable iff (rst) // R12
    ce |=> status_led == $past(filt))
    else $error("Status lights do not follow the filtered levels");

  AST_DIAG_ON: assert property (@(posedge sys_clk) disable iff (rst) // R05
    (ce && par_wr && slot == qfp_pkg::SLOT_DIAG && par_wdata == qfp_pkg::DIAG_ON)
      ##1 ce |=> diag_active)
    else $error("Diagnostics not enabled after 40h write");

  AST_BAD_CODE: assert property (@(posedge sys_clk) disable iff (rst) // R17
    (ce && par_wr && slot inside {[3'h1:3'h4]} && !code_ok(par_wdata))
      |=> par_err && par_ack && st_reg.dly == $past(st_reg.dly))
    else $error("Illegal delay code was not refused");

  AST_RISE: assert property (@(posedge sys_clk) disable iff (rst) // R07 R14
    (edge_event & input_image[3:0] & ~$past(st_reg.rise_mask)) == 4'h0)
    else $error("Rising event on a channel whose mask bit is clear");

  AST_FALL: assert property (@(posedge sys_clk) disable iff (rst) // R08 R15
    (edge_event & ~input_image[3:0] & ~$past(st_reg.fall_mask)) == 4'h0)
    else $error("Falling event on a channel whose mask bit is clear");

  AST_REC_MAP: assert property (@(posedge sys_clk) disable iff (rst) // R09
    (par_mode == qfp_pkg::MODE_RECORD && par_addr == qfp_pkg::REC_MASK && par_sub == 8'h01)
      |-> slot == qfp_pkg::SLOT_FALL)
    else $error("Record 80h byte 1 not mapped to the falling mask");

  AST_OBJ_MAP: assert property (@(posedge sys_clk) disable iff (rst) // R10
    (par_mode == qfp_pkg::MODE_OBJECT && par_addr == 16'h3103) |-> slot == 3'h3)
    else $error("Object index 3103h not mapped to channel 2 delay");

  AST_ECAT_MAP: assert property (@(posedge sys_clk) disable iff (rst) // R11
    (par_mode == qfp_pkg::MODE_ECAT && par_sub == 8'h00) |-> slot == qfp_pkg::SLOT_NONE)
    else $error("Ethernet subindex 00h accepted");

  COV_RISE_EVT: cover property (@(posedge sys_clk) disable iff (rst) |(edge_event & input_image[3:0]));
  COV_FALL_EVT: cover property (@(posedge sys_clk) disable iff (rst) |(edge_event & ~input_image[3:0]));
  COV_BAD_CODE: cover property (@(posedge sys_clk) disable iff (rst) par_ack && par_err);
  COV_DIAG: cover property (@(posedge sys_clk) disable iff (rst) $rose(diag_active));

endmodule : qfp_top

`default_nettype wire

// [dv/qfp_host.sv]
// Host model that issues parameter accesses to the filter block
`timescale 1ns/1ps
`default_nettype none
module qfp_host (
  input  wire logic               sys_clk,
  input  wire logic [7:0]         par_rdata,
  input  wire logic               par_ack,
  input  wire logic               par_err,
  output logic                    par_wr,
  output logic                    par_rd,
  output var qfp_pkg::qfp_mode_t  par_mode,
  output logic [15:0]             par_addr,
  output logic [7:0]              par_sub,
  output logic [7:0]              par_wdata
);
  initial begin
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_mode = qfp_pkg::MODE_RECORD;
    par_addr = 16'h0000;
    par_sub = 8'h00;
    par_wdata = 8'h00;
  end
  // One-cycle request; the ack pulse lasts one cycle, so it is taken before release
  // The host sends the diagnostic-enable record whenever it is called; nothing checks that the system is stopped
  task automatic access(input logic wr, input logic [1:0] md, input logic [15:0] a,
                        input logic [7:0] s, input logic [7:0] wd,
                        output logic [7:0] rd, output logic er, output logic ak);
    @(negedge sys_clk);
    par_wr = wr;
    par_rd = !wr;
    par_mode = qfp_pkg::qfp_mode_t'(md);
    par_addr = a;
    par_sub = s;
    par_wdata = wd;
    @(negedge sys_clk);
    ak = par_ack;
    er = par_err;
    rd = par_rdata;
    par_wr = 1'b0;
    par_rd = 1'b0;
    // Released lines must not keep the last value
    par_addr = ~a;
    par_sub = ~s;
    par_wdata = ~wd;
    // One idle edge so registered status derived from the write has settled
    @(negedge sys_clk);
  endtask : access
endmodule : qfp_host
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench for the four-channel input filter block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int L342  = 200;
  localparam int L2731 = 300;
  logic               sys_clk;
  logic               rst;
  logic               ce;
  logic [3:0]         input_channel;
  logic [7:0]         ecat_slot;
  logic               par_wr;
  logic               par_rd;
  qfp_pkg::qfp_mode_t par_mode;
  logic [15:0]        par_addr;
  logic [7:0]         par_sub;
  logic [7:0]         par_wdata;
  logic [7:0]         par_rdata;
  logic [7:0]         input_image;
  logic               par_ack;
  logic               par_err;
  logic               diag_active;
  logic [3:0]         status_led;
  logic [3:0]         edge_event;
  logic [3:0]         edge_snapshot;
  int                 error_cnt;
  int                 checks;
  int                 seed;
  logic [7:0]         mp [7];
  logic [7:0]         codes [6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0C};
  int                 lims [6] = '{40, 120, 400, 3440, L342, L2731};

  qfp_top #(.CYC_342US(qfp_pkg::CNT_W'(L342)), .CYC_2731US(qfp_pkg::CNT_W'(L2731))) dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .input_channel(input_channel),
    .par_wr(par_wr), .par_rd(par_rd), .par_mode(par_mode), .par_addr(par_addr),
    .par_sub(par_sub), .par_wdata(par_wdata), .ecat_slot(ecat_slot),
    .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
    .input_image(input_image), .status_led(status_led), .diag_active(diag_active),
    .edge_event(edge_event), .edge_snapshot(edge_snapshot));
  qfp_host host (
    .sys_clk(sys_clk), .par_rdata(par_rdata), .par_ack(par_ack), .par_err(par_err),
    .par_wr(par_wr), .par_rd(par_rd), .par_mode(par_mode), .par_addr(par_addr),
    .par_sub(par_sub), .par_wdata(par_wdata));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  task automatic cmp_in(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp({2'b00, got}, {2'b00, exp}, what);
  endtask : cmp_in

  function automatic logic legal(input logic [7:0] v);
    legal = 1'b0;
    foreach (codes[i]) if (codes[i] === v) legal = 1'b1;
  endfunction : legal

  task automatic acc(input logic wr, input logic [1:0] md, input logic [15:0] a,
                     input logic [7:0] s, input logic [7:0] wd, input logic xe,
                     input logic [7:0] xr);
    logic [7:0] rd;
    logic       er;
    logic       ak;
    host.access(wr, md, a, s, wd, rd, er, ak);
    cmp({ak, er, rd}, {1'b1, xe, xr}, "access");
  endtask : acc

  // Parameter slot k: 0 diag, 1..4 delays, 5 rising mask, 6 falling mask
  task automatic slot_acc(input logic wr, input int md, input int k, input logic [7:0] v);
    logic [15:0] a;
    logic [7:0]  s;
    logic        ok;
    logic [7:0]  prev;
    a = 16'h3100 + 16'(k);
    s = 8'h00;
    ok = 1'b1;
    if (md == 2) begin
      a = 16'h3100 + 16'(ecat_slot);
      s = 8'(k + 1);
    end
    if (md == 0) begin
      a = (k == 0) ? 16'h0000 : (k < 5) ? 16'h0001 : 16'h0080;
      s = (k == 0) ? 8'h00 : (k < 5) ? 8'(k - 1) : 8'(k - 5);
    end
    if (wr) ok = (k == 0) ? (v == 8'h00 || v == 8'h40) : (k < 5) ? legal(v) : 1'b1;
    // A mapped slot answers with its old value, on writes as well
    prev = mp[k];
    if (wr && ok) mp[k] = (k > 4) ? (v & 8'h0F) : v;
    acc(wr, 2'(md), a, s, v, !ok, prev);
  endtask : slot_acc

  // A short spike first, then a held level that must pass after the delay
  task automatic edge_run(input int ch, input int lim, input logic lvl);
    logic [7:0] xi;
    logic       xev;
    int         n;
    xi = input_image;
    xi[ch] = lvl;
    xev = lvl ? mp[5][ch] : mp[6][ch];
    input_channel[ch] = lvl;
    repeat (lim / 2) @(negedge sys_clk);
    input_channel[ch] = !lvl;
    repeat (lim + 6) @(negedge sys_clk);
    cmp_in(8'(input_image[ch]), 8'(!lvl), "spike");
    input_channel[ch] = lvl;
    n = 0;
    while (input_image[ch] !== lvl && n < lim + 10) begin
      @(negedge sys_clk);
      n++;
    end
    cmp_in(8'(n >= lim + 1 && n <= lim + 4), 8'h01, "delay");
    cmp_in(input_image, xi, "image");
    cmp_in({4'h0, status_led}, xi, "led");
    cmp_in(8'(edge_event[ch]), 8'(xev), "event");
    if (xev) cmp_in({4'h0, edge_snapshot}, xi, "snapshot");
  endtask : edge_run

  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    repeat (60000) @(posedge sys_clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end

  initial begin
    seed = 32'hadb8;
    error_cnt = 0;
    checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    input_channel = 4'h0;
    ecat_slot = 8'h00;
    mp = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    ecat_slot = 8'($random(seed)) & 8'h1F;
    cmp_in({7'h00, diag_active}, 8'h00, "diag reset");
    for (int md = 0; md < 3; md++) begin
      for (int k = 0; k < 7; k++) slot_acc(1'b0, md, k, 8'h00);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) slot_acc(1'b1, i % 3, 1 + i % 4, codes[i]);
    slot_acc(1'b1, 1, 2, 8'h05);
    slot_acc(1'b1, 2, 3, 8'h0D);
    slot_acc(1'b1, 0, 0, 8'h41);
    acc(1'b0, 2'd1, 16'h3107, 8'h00, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 2'd0, 16'h0002, 8'h00, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 2'd2, 16'h3100 + 16'(ecat_slot), 8'h08, 8'h00, 1'b1, 8'h00);
    acc(1'b0, 2'd2, 16'h3101 + 16'(ecat_slot), 8'h01, 8'h00, 1'b1, 8'h00);
    slot_acc(1'b1, 0, 5, 8'($random(seed)));
    slot_acc(1'b1, 2, 6, 8'($random(seed)));
    for (int k = 0; k < 7; k++) slot_acc(1'b0, 1, k, 8'h00);
    $display("test parameter access done");
    slot_acc(1'b1, 1, 0, 8'h40);
    cmp_in({7'h00, diag_active}, 8'h01, "diag on");
    slot_acc(1'b1, 0, 0, 8'h00);
    cmp_in({7'h00, diag_active}, 8'h00, "diag off");
    $display("test diagnostic enable done");
    for (int i = 0; i < 6; i++) begin
      slot_acc(1'b1, 1, 1 + i % 4, codes[i]);
      edge_run(i % 4, lims[i], 1'b1);
      edge_run(i % 4, lims[i], 1'b0);
    end
    $display("test filter delays done");
    for (int k = 1; k < 5; k++) slot_acc(1'b1, 1, k, 8'h00);
    repeat (3) begin
      input_channel = 4'($random(seed));
      repeat (50) @(negedge sys_clk);
      cmp_in(input_image, {4'h0, input_channel}, "all channels");
    end
    ce = 1'b0;
    input_channel = ~input_channel;
    repeat (60) @(negedge sys_clk);
    cmp_in(input_image, {4'h0, ~input_channel}, "frozen");
    ce = 1'b1;
    repeat (50) @(negedge sys_clk);
    cmp_in(input_image, {4'h0, input_channel}, "thawed");
    $display("test simultaneous channels done");
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    mp = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00};
    cmp_in(input_image, 8'h00, "image after reset");
    for (int k = 0; k < 7; k++) slot_acc(1'b0, 2, k, 8'h00);
    $display("test reset in run done");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
